// File: include/dsc_pkg.sv
// constants and types shared by the dual-slope converter control logic
package dsc_pkg;
  localparam int unsigned OSC_DIV        = 4;
  localparam int unsigned DIV_W          = 2;
  localparam int unsigned CNT_W          = 12;
  localparam logic [11:0] CYCLE_COUNTS   = 12'hfa0; // 4000
  localparam logic [11:0] SIGNAL_COUNTS  = 12'h3e8; // 1000
  localparam logic [11:0] REF_MAX_COUNTS = 12'h7d0; // 2000
  localparam logic [11:0] AZ_MIN_COUNTS  = 12'h3e8; // 1000
  localparam logic [11:0] PLANE_HALF     = 12'h064; // 4000/40 counts
  localparam logic [11:0] FULL_SCALE     = 12'h7cf; // 1999
  localparam logic [3:0]  DIGIT_MAX      = 4'h9;
  localparam logic [6:0]  SEG_BLANK      = 7'h00;
  localparam logic [6:0]  SEG_DASH       = 7'h40; // overflow shows g only

  typedef enum logic [2:0]
  {
    PH_AZ  = 3'b001,
    PH_SIG = 3'b010,
    PH_REF = 3'b100
  } phase_t;
endpackage

// File: rtl/seg7_drive.sv
// seven-segment decode with lamp test and ac phase against the common plane
`timescale 1ns/1ps
module seg7_drive
(
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic [3:0] digit_in,
  input  wire logic       blank_in,
  input  wire logic       dash_in,
  input  wire logic       test_in,
  input  wire logic       plane_in,
  output logic      [6:0] seg_out
);
  logic [6:0] pat;
  logic [6:0] seg_next;
  logic [6:0] seg_reg;

  // bit order g f e d c b a
  always_comb
  begin
    unique case (digit_in)
      4'h0: pat = 7'h3f;
      4'h1: pat = 7'h06;
      4'h2: pat = 7'h5b;
      4'h3: pat = 7'h4f;
      4'h4: pat = 7'h66;
      4'h5: pat = 7'h6d;
      4'h6: pat = 7'h7d;
      4'h7: pat = 7'h07;
      4'h8: pat = 7'h7f;
      4'h9: pat = 7'h6f;
      default: pat = dsc_pkg::SEG_BLANK;
    endcase
    if (dash_in)
      pat = dsc_pkg::SEG_DASH;
    else if (blank_in)
      pat = dsc_pkg::SEG_BLANK;
    if (test_in)
      pat = 7'h7f;
    // lit segment runs in antiphase with the plane
    seg_next = pat ^ {7{plane_in}};
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      seg_reg <= 7'h00;
    else
      seg_reg <= seg_next;
  end

  assign seg_out = seg_reg;
endmodule

// File: rtl/dual_slope_count_lcd_driver.sv
// dual-slope converter sequencer, result latch and static lcd drive
`timescale 1ns/1ps
module dual_slope_count_lcd_driver
(
  input  wire logic       mclk_in,
  input  wire logic       rst_in,
  input  wire logic       zero_cross_in,
  input  wire logic       input_negative_in,
  input  wire logic       lamp_test_in,
  output logic            auto_zero_out,
  output logic            signal_int_out,
  output logic            reference_int_out,
  output logic            lcd_common_plane_drive,
  output logic            sign_segment_out,
  output logic            leading_one_segment,
  output logic      [6:0] hundreds_seg_out,
  output logic      [6:0] tens_seg_out,
  output logic      [6:0] units_seg_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  // pin inputs pass two flip-flops first
  logic [1:0] zc_sync_reg;
  logic [1:0] neg_sync_reg;
  logic [1:0] test_sync_reg;
  logic       zc_s;
  logic       neg_s;
  logic       test_s;

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      zc_sync_reg   <= 2'h0;
      neg_sync_reg  <= 2'h0;
      test_sync_reg <= 2'h0;
    end
    else
    begin
      zc_sync_reg   <= {zc_sync_reg[0], zero_cross_in};
      neg_sync_reg  <= {neg_sync_reg[0], input_negative_in};
      test_sync_reg <= {test_sync_reg[0], lamp_test_in};
    end
  end

  assign zc_s   = zc_sync_reg[1];
  assign neg_s  = neg_sync_reg[1];
  assign test_s = test_sync_reg[1];

  // sequencer state
  logic [dsc_pkg::DIV_W-1:0] div_reg,    div_next;
  logic                      tick;
  dsc_pkg::phase_t           phase_reg,  phase_next;
  logic [11:0]               cyc_reg,    cyc_next;
  logic [11:0]               ph_reg,     ph_next;
  logic                      neg_reg,    neg_next;
  logic [11:0]               res_reg,    res_next;
  logic                      rneg_reg,   rneg_next;
  logic                      ovf_reg,    ovf_next;
  logic [11:0]               pl_reg,     pl_next;
  logic                      plane_reg,  plane_next;

  assign tick = (div_reg == dsc_pkg::DIV_W'(dsc_pkg::OSC_DIV - 1));

  always_comb
  begin
    div_next   = div_reg + 1'b1;
    phase_next = phase_reg;
    cyc_next   = cyc_reg;
    ph_next    = ph_reg;
    neg_next   = neg_reg;
    res_next   = res_reg;
    rneg_next  = rneg_reg;
    ovf_next   = ovf_reg;
    pl_next    = pl_reg;
    plane_next = plane_reg;
    if (tick)
    begin
      // plane half period is cycle/40, so it runs at 20x conversion rate
      if (pl_reg == dsc_pkg::PLANE_HALF - 12'h001)
      begin
        pl_next    = 12'h000;
        plane_next = ~plane_reg;
      end
      else
        pl_next = pl_reg + 12'h001;
      ph_next = ph_reg + 12'h001;
      if (cyc_reg == dsc_pkg::CYCLE_COUNTS - 12'h001)
        cyc_next = 12'h000;
      else
        cyc_next = cyc_reg + 12'h001;
      unique case (phase_reg)
        dsc_pkg::PH_AZ:
        begin
          // auto-zero ends only when the 4000-count cycle wraps
          if (cyc_reg == dsc_pkg::CYCLE_COUNTS - 12'h001)
          begin
            phase_next = dsc_pkg::PH_SIG;
            ph_next    = 12'h000;
          end
        end
        dsc_pkg::PH_SIG:
        begin
          if (ph_reg == dsc_pkg::SIGNAL_COUNTS - 12'h001)
          begin
            phase_next = dsc_pkg::PH_REF;
            ph_next    = 12'h000;
            neg_next   = neg_s; // polarity fixed at end of input phase
          end
        end
        dsc_pkg::PH_REF:
        begin
          if (zc_s)
          begin
            phase_next = dsc_pkg::PH_AZ;
            res_next   = ph_reg;
            rneg_next  = neg_reg;
            ovf_next   = 1'b0;
          end
          else if (ph_reg == dsc_pkg::REF_MAX_COUNTS - 12'h001)
          begin
            phase_next = dsc_pkg::PH_AZ;
            res_next   = dsc_pkg::FULL_SCALE;
            rneg_next  = neg_reg;
            ovf_next   = 1'b1;
          end
        end
        default:
        begin
          phase_next = dsc_pkg::PH_AZ;
          cyc_next   = 12'h000;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      div_reg   <= '0;
      phase_reg <= dsc_pkg::PH_AZ;
      cyc_reg   <= 12'h000;
      ph_reg    <= 12'h000;
      neg_reg   <= 1'b0;
      res_reg   <= 12'h000;
      rneg_reg  <= 1'b0;
      ovf_reg   <= 1'b0;
      pl_reg    <= 12'h000;
      plane_reg <= 1'b0;
    end
    else
    begin
      div_reg   <= div_next;
      phase_reg <= phase_next;
      cyc_reg   <= cyc_next;
      ph_reg    <= ph_next;
      neg_reg   <= neg_next;
      res_reg   <= res_next;
      rneg_reg  <= rneg_next;
      ovf_reg   <= ovf_next;
      pl_reg    <= pl_next;
      plane_reg <= plane_next;
    end
  end

  // binary result to decimal digits; result never exceeds 1999
  logic [3:0] d_th, d_hu, d_te, d_un;
  logic [11:0] rem;
  always_comb
  begin
    rem  = res_reg;
    d_th = (rem >= 12'h3e8) ? 4'h1 : 4'h0;
    rem  = (rem >= 12'h3e8) ? rem - 12'h3e8 : rem;
    d_hu = 4'(rem / 12'h064);
    // products kept 12 bits wide: 9 x 100 overflows a byte
    rem  = rem - 12'(d_hu) * 12'h064;
    d_te = 4'(rem / 12'h00a);
    d_un = 4'(rem - 12'(d_te) * 12'h00a);
  end

  // output flops
  logic ctl_az_reg, ctl_sig_reg, ctl_ref_reg, one_reg, sign_reg;
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ctl_az_reg  <= 1'b0;
      ctl_sig_reg <= 1'b0;
      ctl_ref_reg <= 1'b0;
      one_reg     <= 1'b0;
      sign_reg    <= 1'b0;
    end
    else
    begin
      ctl_az_reg  <= phase_next == dsc_pkg::PH_AZ;
      ctl_sig_reg <= phase_next == dsc_pkg::PH_SIG;
      ctl_ref_reg <= phase_next == dsc_pkg::PH_REF;
      one_reg     <= ((d_th != 4'h0) | test_s) ^ plane_next;
      sign_reg    <= (rneg_reg | test_s) ^ plane_next;
    end
  end

  assign auto_zero_out          = ctl_az_reg;
  assign signal_int_out         = ctl_sig_reg;
  assign reference_int_out      = ctl_ref_reg;
  assign lcd_common_plane_drive = plane_reg;
  assign leading_one_segment    = one_reg;
  assign sign_segment_out       = sign_reg;

  // hundreds, tens and units digits each show a dash when over range
  seg7_drive u_hundreds
  (
    .clk_in   (mclk_in),
    .rst_in   (rst_in),
    .digit_in (d_hu),
    .blank_in (1'b0),
    .dash_in  (ovf_reg),
    .test_in  (test_s),
    .plane_in (plane_next),
    .seg_out  (hundreds_seg_out)
  );
  seg7_drive u_tens
  (
    .clk_in   (mclk_in),
    .rst_in   (rst_in),
    .digit_in (d_te),
    .blank_in (1'b0),
    .dash_in  (ovf_reg),
    .test_in  (test_s),
    .plane_in (plane_next),
    .seg_out  (tens_seg_out)
  );
  seg7_drive u_units
  (
    .clk_in   (mclk_in),
    .rst_in   (rst_in),
    .digit_in (d_un),
    .blank_in (1'b0),
    .dash_in  (ovf_reg),
    .test_in  (test_s),
    .plane_in (plane_next),
    .seg_out  (units_seg_out)
  );

  property p_sig_len;
    $rose(signal_int_out) |-> signal_int_out [*8];
  endproperty
  a_sig_len: assert property (p_sig_len) else $error("sig short");
  property p_sig_then_ref;
    $fell(signal_int_out) |-> reference_int_out;
  endproperty
  a_sig_then_ref: assert property (p_sig_then_ref)
    else $error("no ref");
  property p_ref_max;
    reference_int_out |-> ph_reg < dsc_pkg::REF_MAX_COUNTS;
  endproperty
  a_ref_max: assert property (p_ref_max) else $error("ref too long");
  property p_cycle;
    cyc_reg < dsc_pkg::CYCLE_COUNTS;
  endproperty
  a_cycle: assert property (p_cycle) else $error("cycle overrun");
  property p_div;
    tick |=> !tick [*3];
  endproperty
  a_div: assert property (p_div) else $error("divider wrong");
  property p_res;
    res_reg <= dsc_pkg::FULL_SCALE;
  endproperty
  a_res: assert property (p_res) else $error("result above 1999");
  property p_zc_latch;
    (tick && phase_reg == dsc_pkg::PH_REF && zc_s)
      |=> res_reg == $past(ph_reg);
  endproperty
  a_zc_latch: assert property (p_zc_latch) else $error("result lost");
  property p_test;
    test_s |=> units_seg_out == ~{7{lcd_common_plane_drive}};
  endproperty
  a_test: assert property (p_test) else $error("lamp test fail");
  property p_sign_phase;
    (!test_s && !rneg_reg) |=> sign_segment_out == lcd_common_plane_drive;
  endproperty
  a_sign_phase: assert property (p_sign_phase) else $error("sign");
  c_ref: cover property (@(posedge mclk_in) $fell(reference_int_out));
  c_ovf: cover property (@(posedge mclk_in) $rose(ovf_reg));
  c_plane: cover property (@(posedge mclk_in) $rose(lcd_common_plane_drive));
endmodule

// File: verif/lcd_panel_model.sv
// static lcd panel model that reads the number shown on the glass
`timescale 1ns/1ps
module lcd_panel_model
(
  input  wire logic        plane_in,
  input  wire logic        sign_in,
  input  wire logic        lead_in,
  input  wire logic [6:0]  hundreds_in,
  input  wire logic [6:0]  tens_in,
  input  wire logic [6:0]  units_in,
  output logic      [15:0] value_out,
  output logic             minus_out
);
  logic [6:0] ph;

  function automatic logic [15:0] digit(input logic [6:0] s);
    case (s)
      7'h00, 7'h3f: return 16'h0000;
      7'h06:        return 16'h0001;
      7'h5b:        return 16'h0002;
      7'h4f:        return 16'h0003;
      7'h66:        return 16'h0004;
      7'h6d:        return 16'h0005;
      7'h7d, 7'h7c: return 16'h0006;
      7'h07, 7'h27: return 16'h0007;
      7'h7f:        return 16'h0008;
      7'h6f, 7'h67: return 16'h0009;
      // an unreadable glyph spoils the whole reading
      default:      return 16'h0fff;
    endcase
  endfunction

  // a segment is visible only while its drive opposes the plane
  assign ph        = {7{plane_in}};
  assign minus_out = sign_in ^ plane_in;
  assign value_out = ((lead_in ^ plane_in) ? 16'h03e8 : 16'h0000)
                   + 16'h0064 * digit(hundreds_in ^ ph)
                   + 16'h000a * digit(tens_in ^ ph)
                   + digit(units_in ^ ph);
endmodule

// File: verif/dual_slope_count_lcd_driver_tb_top.sv
// self-checking bench for the converter sequencer and lcd drive
`timescale 1ns/1ps
module dual_slope_count_lcd_driver_tb_top;
  logic        mclk_in           = 1'b0;
  logic        rst_in            = 1'b1;
  logic        zero_cross_in     = 1'b0;
  logic        input_negative_in = 1'b0;
  logic        lamp_test_in      = 1'b0;
  logic        az;
  logic        si;
  logic        ri;
  logic        plane;
  logic        sgn;
  logic        lead;
  logic [6:0]  hs;
  logic [6:0]  ts;
  logic [6:0]  us;
  logic [15:0] shown;
  logic        minus;
  int          errors       = 0;
  int          total_checks = 0;
  int          n;

  always #2.5 mclk_in = ~mclk_in;

  dual_slope_count_lcd_driver uut
  (
    .mclk_in(mclk_in), .rst_in(rst_in), .zero_cross_in(zero_cross_in),
    .input_negative_in(input_negative_in), .lamp_test_in(lamp_test_in),
    .auto_zero_out(az), .signal_int_out(si), .reference_int_out(ri),
    .lcd_common_plane_drive(plane), .sign_segment_out(sgn),
    .leading_one_segment(lead), .hundreds_seg_out(hs),
    .tens_seg_out(ts), .units_seg_out(us)
  );

  lcd_panel_model panel
  (
    .plane_in(plane), .sign_in(sgn), .lead_in(lead), .hundreds_in(hs),
    .tens_in(ts), .units_in(us), .value_out(shown), .minus_out(minus)
  );

  function automatic logic get(input int sel);
    case (sel)
      0:       return si;
      1:       return ri;
      default: return plane;
    endcase
  endfunction

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      errors++;
    end
  endtask

  task automatic tick(input int c);
    repeat (c) @(posedge mclk_in);
    #1;
  endtask

  // counts clocks until the selected output reaches lvl, bounded
  task automatic wait_lvl(input int sel, input logic lvl, input int lim,
                          output int cnt);
    cnt = 0;
    while (get(sel) !== lvl && cnt < lim)
    begin
      tick(1);
      cnt++;
    end
    if (cnt >= lim)
    begin
      check("bounded wait", 16'(lvl), 16'(get(sel)));
      tally_and_finish();
    end
  endtask

  task automatic t_reset();
    tick(3);
    check("outputs in reset", 16'h0000,
          16'({hs | ts | us, plane, sgn, lead, az, si, ri}));
    rst_in = 1'b0;
    tick(2);
    check("auto-zero after reset", 16'h0001, 16'(az));
  endtask

  // negative input, crossing after k counts of reference
  task automatic t_convert(input int k);
    input_negative_in = 1'b1;
    wait_lvl(0, 1'b1, 20000, n);
    wait_lvl(0, 1'b0, 5000, n);
    check("input phase clocks", 16'h0fa0, 16'(n));
    tick(k * 4);
    zero_cross_in = 1'b1;
    wait_lvl(1, 1'b0, 9000, n);
    zero_cross_in = 1'b0;
    input_negative_in = 1'b0;
    check("stop after crossing", 16'h0001, 16'(n <= 12));
    check("auto-zero after crossing", 16'h0001, 16'(az));
    tick(8);
    check("reading not below", 16'h0001, 16'(shown >= k));
    check("reading not above", 16'h0001, 16'(shown <= k + 3));
    check("minus shown", 16'h0001, 16'(minus));
    tick(800);
    check("reading held", 16'h0001, 16'(shown >= k && shown <= k + 3));
  endtask

  // no crossing at all: full reference length, then overflow glyphs
  task automatic t_overflow();
    logic [6:0] pv;
    wait_lvl(0, 1'b1, 20000, n);
    wait_lvl(0, 1'b0, 5000, n);
    wait_lvl(1, 1'b0, 9000, n);
    check("reference clocks", 16'h1f40, 16'(n));
    wait_lvl(0, 1'b1, 20000, n);
    check("auto-zero clocks", 16'h0fa0, 16'(n));
    tick(4);
    pv = {7{plane}};
    check("lead lit", 16'h0001, 16'(lead ^ plane));
    check("hundreds dash", 16'(dsc_pkg::SEG_DASH), 16'(hs ^ pv));
    check("tens dash", 16'(dsc_pkg::SEG_DASH), 16'(ts ^ pv));
    check("units dash", 16'(dsc_pkg::SEG_DASH), 16'(us ^ pv));
    check("off segment in phase", 16'(plane), 16'(us[0]));
    check("on segment inverted", 16'(!plane), 16'(us[6]));
    check("no minus", 16'h0000, 16'(minus));
  endtask

  task automatic t_plane();
    logic p;
    p = plane;
    wait_lvl(2, ~p, 1000, n);
    wait_lvl(2, p, 1000, n);
    check("plane half period", 16'h0190, 16'(n));
  endtask

  task automatic t_lamp();
    lamp_test_in = 1'b1;
    tick(6);
    check("lamp reading", 16'h0760, shown);
    check("lamp minus", 16'h0001, 16'(minus));
    lamp_test_in = 1'b0;
    tick(6);
    check("lamp released", 16'h0001, 16'(shown !== 16'h0760));
  endtask

  initial
  begin
    t_reset();
    t_convert(500);
    t_convert(1999);
    t_overflow();
    t_plane();
    t_lamp();
    tally_and_finish();
  end
endmodule
